// ### hw/i2c_target.sv
// two-wire register target: pointer byte, auto-incrementing writes and reads
`timescale 1ns/1ps
`default_nettype none
module i2c_target
  import sensor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic [7:0] rdata_in,
  output reg_req_t        req_out,
  output logic            sda_oe_out
);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       start;
  logic       stop;
  logic       rise;
  logic       fall;
  bus_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic       ack_q;
  logic       rw_q;
  logic       wr_q;
  logic       oe_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  assign start = scl_s_q[1] && scl_p_q && sda_p_q && !sda_s_q[1];
  assign stop = scl_s_q[1] && scl_p_q && !sda_p_q && sda_s_q[1];
  assign rise = scl_s_q[1] && !scl_p_q;
  assign fall = !scl_s_q[1] && scl_p_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= BUS_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      wr_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (start) begin
        st_q <= BUS_ADDR;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (stop) begin
        st_q <= BUS_IDLE;
        ack_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (st_q == BUS_READ) begin
        if (fall && (cnt_q == 4'ha)) begin
          oe_q <= !rdata_in[7];
          sh_q <= {rdata_in[6:0], 1'b0};
          cnt_q <= 4'h1;
        end else if (fall && (cnt_q < 4'h8)) begin
          oe_q <= !sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
          cnt_q <= cnt_q + 4'h1;
        end else if (fall && (cnt_q == 4'h8)) begin
          oe_q <= 1'b0;
          cnt_q <= 4'h9;
        end else if (rise && (cnt_q == 4'h9)) begin
          // a not-acknowledge from the reader ends the burst
          if (sda_s_q[1]) begin
            st_q <= BUS_IDLE;
          end else begin
            ptr_q <= ptr_q + 8'h01;
            cnt_q <= 4'ha;
          end
        end
      end else if (st_q != BUS_IDLE) begin
        if (rise && (cnt_q < 4'h8) && !ack_q) begin
          sh_q <= {sh_q[6:0], sda_s_q[1]};
          cnt_q <= cnt_q + 4'h1;
        end else if (fall && (cnt_q == 4'h8) && !ack_q) begin
          ack_q <= 1'b1;
          oe_q <= 1'b1;
          if (st_q == BUS_ADDR) begin
            rw_q <= sh_q[0];
            if (sh_q[7:1] != DEV_ADDR) begin
              st_q <= BUS_IDLE;
              ack_q <= 1'b0;
              oe_q <= 1'b0;
            end
          end else if (st_q == BUS_PTR) begin
            ptr_q <= sh_q;
          end else begin
            wr_q <= 1'b1;
          end
        end else if (fall && ack_q) begin
          ack_q <= 1'b0;
          oe_q <= 1'b0;
          cnt_q <= 4'h0;
          if ((st_q == BUS_ADDR) && rw_q) begin
            st_q <= BUS_READ;
            oe_q <= !rdata_in[7];
            sh_q <= {rdata_in[6:0], 1'b0};
            cnt_q <= 4'h1;
          end else if (st_q == BUS_ADDR) begin
            st_q <= BUS_PTR;
          end else if (st_q == BUS_PTR) begin
            st_q <= BUS_WRITE;
          end else begin
            ptr_q <= ptr_q + 8'h01;
          end
        end
      end
    end
  end
  assign req_out = '{wr: wr_q, addr: ptr_q, wdata: sh_q};
  assign sda_oe_out = oe_q;
endmodule
`default_nettype wire

// ### hw/sensor_defs.svh
// register offsets, field positions, reset values and timing of the sensor block
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH
`define ADDR_FUNCTION_ENABLE 8'h80
`define ADDR_INTEG_TIME 8'h81
`define ADDR_WAIT_TIME 8'h83
`define ADDR_STATUS 8'h93
`define ADDR_COLOR_BASE 8'h94
`define ADDR_PROX_LO 8'h9c
`define ADDR_PROX_HI 8'h9d
`define BIT_POWER_ON 0
`define BIT_COLOR_EN 1
`define BIT_PROX_EN 2
`define BIT_WAIT_EN 3
`define BIT_LIGHT_IRQ_EN 4
`define BIT_PROX_IRQ_EN 5
`define BIT_GESTURE_EN 6
`define STAT_COLOR_VALID 0
`define STAT_PROX_VALID 1
`define RST_FUNCTION_ENABLE 8'h00
`define RST_INTEG_TIME 8'hff
`define RST_WAIT_TIME 8'hff
`define ENABLE_WRITE_MASK 8'h7f
`define CYCLE_SPAN 9'h100
`define COUNT_PER_CYCLE 19'h00400
`define COUNT_CEILING 19'h0ffff
`define COLOR_CHANNELS 4
`define SAMPLE_W 11
`define STEP_TIME_NS 2780000
`define CLK_PERIOD_NS 25
`endif

// ### hw/sensor_enable_and_als_timing.sv
// top: enable and timing registers, measurement sequencer, colour result capture
`timescale 1ns/1ps
`default_nettype none
`include "sensor_defs.svh"

// Overview of operation
// R1 - writing power-on as one starts the oscillator so timers and converters run
// R2 - writing power-on as zero stops oscillator and clears prox and colour enables
// R3 - host sets power-on only after all other configuration is written
// R4 - colour-enable bit turns light and colour measurement on or off
// R5 - prox-enable bit turns proximity measurement on or off
// R6 - wait bit starts the wait timer between cycles, zero disables it
// R7 - light interrupts pass only while the light interrupt enable is set
// R8 - proximity interrupts pass only while the prox interrupt enable is set
// R9 - gesture enable lets gesture start on mode field or prox above entry level
// R10 - host writes a function's configuration before setting its enable
// R11 - host avoids changing control values while measurements run
// R12 - integration lasts 256 minus integration field steps of 2.78 ms
// R13 - integration field resets to 0xff, a single integration cycle
// R14 - colour results saturate at smaller of 65535 and 1024 per cycle
// R15 - enable register resets to zero, every function and oscillator off
// R16 - wait timer pauses 256 minus wait field steps of 2.78 ms
// R17 - with power off timers stop, results hold, registers stay reachable
module sensor_enable_and_als_timing
  import sensor_pkg::*;
#(
  parameter int STEP_CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS,
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire color_sample_t color_sample_in,
  input  wire logic [15:0] prox_sample_in,
  input  wire logic       gesture_mode_in,
  input  wire logic [15:0] gesture_entry_thr_in,
  input  wire irq_req_t   irq_req_in,
  output logic            osc_run_out,
  output logic            color_active_out,
  output logic            prox_active_out,
  output logic            wait_active_out,
  output logic            light_irq_out,
  output logic            prox_irq_out,
  output logic            gesture_active_out
);
  localparam int CH = `COLOR_CHANNELS;

  logic [1:0] rst_sync_q;
  logic       rst_b;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  reg_req_t   req;
  logic [7:0] rdata;

  i2c_target #(
    .DEV_ADDR(DEV_ADDR)
  ) u_bus (
    .clk_in    (ref_clk_in),
    .rst_b_in  (rst_b),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .rdata_in  (rdata),
    .req_out   (req),
    .sda_oe_out(sda_oe_out)
  );
  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  logic [7:0] enable_q;
  logic [7:0] als_integration_time_q;
  logic [7:0] wait_time_field_q;
  logic       wr_enable;
  logic       osc_run;
  logic       color_en;
  logic       prox_en;
  logic       wait_en;

  assign wr_enable = req.wr && (req.addr == `ADDR_FUNCTION_ENABLE);

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= `RST_FUNCTION_ENABLE; // R15
    end else if (wr_enable) begin
      enable_q <= req.wdata & `ENABLE_WRITE_MASK;
      if (!req.wdata[`BIT_POWER_ON]) begin
        enable_q[`BIT_COLOR_EN] <= 1'b0; // R2
        enable_q[`BIT_PROX_EN] <= 1'b0; // R2
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      als_integration_time_q <= `RST_INTEG_TIME; // R13
      wait_time_field_q <= `RST_WAIT_TIME;
    end else if (req.wr && (req.addr == `ADDR_INTEG_TIME)) begin
      als_integration_time_q <= req.wdata;
    end else if (req.wr && (req.addr == `ADDR_WAIT_TIME)) begin
      wait_time_field_q <= req.wdata;
    end
  end

  assign osc_run = enable_q[`BIT_POWER_ON]; // R1
  assign color_en = enable_q[`BIT_COLOR_EN];
  assign prox_en = enable_q[`BIT_PROX_EN];
  assign wait_en = enable_q[`BIT_WAIT_EN];
  assign osc_run_out = osc_run;

  logic step;

  step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_step (
    .clk_in  (ref_clk_in),
    .rst_b_in(rst_b),
    .run_in  (osc_run), // R1 R17
    .step_out(step)
  );

  seq_state_t state_q;
  logic [8:0] step_cnt_q;
  logic [8:0] als_cycles;
  logic [8:0] wait_cycles;
  logic       als_step;
  logic       als_done;
  logic       prox_done;
  logic       wait_last;

  assign als_cycles = `CYCLE_SPAN - {1'b0, als_integration_time_q}; // R12
  assign wait_cycles = `CYCLE_SPAN - {1'b0, wait_time_field_q}; // R16
  assign als_step = step && (state_q == SEQ_ALS) && color_en;
  assign als_done = als_step && ((step_cnt_q + 9'h001) == als_cycles); // R12
  assign prox_done = step && (state_q == SEQ_PROX) && prox_en;
  assign wait_last = step && ((step_cnt_q + 9'h001) == wait_cycles); // R16

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SEQ_IDLE;
      step_cnt_q <= 9'h000;
    end else if (!osc_run) begin
      state_q <= SEQ_IDLE; // R17
      step_cnt_q <= 9'h000;
    end else begin
      unique case (state_q)
        SEQ_IDLE: begin
          step_cnt_q <= 9'h000;
          if (prox_en) begin
            state_q <= SEQ_PROX; // R5
          end else if (color_en) begin
            state_q <= SEQ_ALS; // R4
          end
        end
        SEQ_PROX: begin
          if (!prox_en) begin
            state_q <= SEQ_IDLE; // R5
          end else if (step) begin
            step_cnt_q <= 9'h000;
            if (color_en) begin
              state_q <= SEQ_ALS;
            end else if (wait_en) begin
              state_q <= SEQ_WAIT;
            end else begin
              state_q <= SEQ_IDLE;
            end
          end
        end
        SEQ_ALS: begin
          if (!color_en) begin
            state_q <= SEQ_IDLE; // R4
          end else if (als_done) begin
            step_cnt_q <= 9'h000;
            state_q <= wait_en ? SEQ_WAIT : SEQ_IDLE; // R6
          end else if (step) begin
            step_cnt_q <= step_cnt_q + 9'h001;
          end
        end
        SEQ_WAIT: begin
          if (!wait_en || wait_last) begin
            state_q <= SEQ_IDLE; // R6 R16
            step_cnt_q <= 9'h000;
          end else if (step) begin
            step_cnt_q <= step_cnt_q + 9'h001;
          end
        end
      endcase
    end
  end

  assign color_active_out = (state_q == SEQ_ALS);
  assign prox_active_out = (state_q == SEQ_PROX);
  assign wait_active_out = (state_q == SEQ_WAIT);

  // per-cycle ceiling; never above the 16-bit limit
  logic [18:0] cycle_cap;
  logic [18:0] sat_limit;
  logic [CH-1:0][15:0] color_word;

  assign cycle_cap = 19'(als_cycles * `COUNT_PER_CYCLE); // R14
  assign sat_limit = (cycle_cap > `COUNT_CEILING) ? `COUNT_CEILING : cycle_cap; // R14

  for (genvar ch = 0; ch < CH; ch++) begin : g_chan
    logic [15:0] acc_q;
    logic [15:0] result_q;
    logic [18:0] sum;
    logic [15:0] acc_next;
    // first step of a cycle starts from zero rather than last result
    assign sum = ((step_cnt_q == 9'h000) ? 19'h00000 : {3'h0, acc_q})
               + {8'h00, color_sample_in[ch]};
    assign acc_next = (sum > sat_limit) ? sat_limit[15:0] : sum[15:0]; // R14
    always_ff @(posedge ref_clk_in or negedge rst_b) begin
      if (!rst_b) begin
        acc_q <= 16'h0000;
      end else if (als_step) begin
        acc_q <= acc_next; // R17
      end
    end
    always_ff @(posedge ref_clk_in or negedge rst_b) begin
      if (!rst_b) begin
        result_q <= 16'h0000;
      end else if (als_done) begin
        result_q <= acc_next;
      end
    end
    assign color_word[ch] = result_q;
  end

  logic [15:0] prox_q;
  logic        color_valid_q;
  logic        prox_valid_q;

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      prox_q <= 16'h0000;
    end else if (prox_done) begin
      prox_q <= prox_sample_in; // R17
    end
  end

  // a new result wins over a clear from a disabled function
  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      color_valid_q <= 1'b0;
      prox_valid_q <= 1'b0;
    end else begin
      if (als_done) begin
        color_valid_q <= 1'b1;
      end else if (!color_en) begin
        color_valid_q <= 1'b0;
      end
      if (prox_done) begin
        prox_valid_q <= 1'b1;
      end else if (!prox_en) begin
        prox_valid_q <= 1'b0;
      end
    end
  end

  logic light_irq_q;
  logic prox_irq_q;
  logic gesture_q;

  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      light_irq_q <= 1'b0;
      prox_irq_q <= 1'b0;
      gesture_q <= 1'b0;
    end else begin
      light_irq_q <= irq_req_in.light && enable_q[`BIT_LIGHT_IRQ_EN]; // R7
      prox_irq_q <= irq_req_in.prox && enable_q[`BIT_PROX_IRQ_EN]; // R8
      gesture_q <= enable_q[`BIT_GESTURE_EN] && osc_run
                && (gesture_mode_in || (prox_q > gesture_entry_thr_in)); // R9
    end
  end
  assign light_irq_out = light_irq_q;
  assign prox_irq_out = prox_irq_q;
  assign gesture_active_out = gesture_q;

  logic [7:0] color_off;
  assign color_off = req.addr - `ADDR_COLOR_BASE;

  // reads never depend on the oscillator
  always_comb begin
    rdata = 8'h00;
    if (req.addr == `ADDR_FUNCTION_ENABLE) begin
      rdata = enable_q; // R17
    end else if (req.addr == `ADDR_INTEG_TIME) begin
      rdata = als_integration_time_q;
    end else if (req.addr == `ADDR_WAIT_TIME) begin
      rdata = wait_time_field_q;
    end else if (req.addr == `ADDR_STATUS) begin
      rdata[`STAT_COLOR_VALID] = color_valid_q;
      rdata[`STAT_PROX_VALID] = prox_valid_q;
    end else if ((req.addr >= `ADDR_COLOR_BASE) && (req.addr < `ADDR_PROX_LO)) begin
      rdata = color_off[0] ? color_word[color_off[2:1]][15:8]
                           : color_word[color_off[2:1]][7:0];
    end else if (req.addr == `ADDR_PROX_LO) begin
      rdata = prox_q[7:0];
    end else if (req.addr == `ADDR_PROX_HI) begin
      rdata = prox_q[15:8];
    end
  end

  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b);

  logic [8:0] als_seen_q;
  always_ff @(posedge ref_clk_in or negedge rst_b) begin
    if (!rst_b) begin
      als_seen_q <= 9'h000;
    end else if (state_q != SEQ_ALS) begin
      als_seen_q <= 9'h000;
    end else if (step) begin
      als_seen_q <= als_seen_q + 9'h001;
    end
  end

  chk_power_start: assert property ( // R1
    wr_enable && req.wdata[`BIT_POWER_ON] |=> osc_run_out ##1 1'b1)
    else $error("oscillator did not start after power-on write");
  chk_power_stop: assert property ( // R2
    wr_enable && !req.wdata[`BIT_POWER_ON]
    |=> !osc_run_out && !color_en && !prox_en ##2 state_q == SEQ_IDLE)
    else $error("power-off write did not stop and clear functions");
  chk_color_bit: assert property ( // R4
    wr_enable |=> color_en == ($past(req.wdata[`BIT_COLOR_EN])
                             && $past(req.wdata[`BIT_POWER_ON])))
    else $error("colour enable does not follow write");
  chk_prox_bit: assert property ( // R5
    wr_enable && req.wdata[`BIT_PROX_EN] && req.wdata[`BIT_POWER_ON]
    |=> prox_en ##1 state_q != SEQ_ALS)
    else $error("proximity enable does not follow write");
  chk_wait_off: assert property ( // R6
    state_q == SEQ_WAIT && !wait_en |=> state_q == SEQ_IDLE)
    else $error("wait kept running with wait disabled");
  chk_light_gate: assert property ( // R7
    !enable_q[`BIT_LIGHT_IRQ_EN] |=> !light_irq_out)
    else $error("light interrupt raised while disabled");
  chk_prox_gate: assert property ( // R8
    !enable_q[`BIT_PROX_IRQ_EN] |=> !prox_irq_out)
    else $error("proximity interrupt raised while disabled");
  chk_gesture_gate: assert property ( // R9
    gesture_active_out |-> $past(enable_q[`BIT_GESTURE_EN]) && $past(osc_run))
    else $error("gesture active without gesture enable");
  chk_integ_len: assert property ( // R12
    als_done |-> (als_seen_q + 9'h001) == als_cycles)
    else $error("integration length differs from field setting");
  chk_color_cap: assert property ( // R14
    als_done |=> color_word[0] <= $past(sat_limit[15:0]) && color_valid_q)
    else $error("colour result above saturation limit");
  chk_off_hold: assert property ( // R17
    !osc_run && !$past(osc_run) |-> !step && $stable(color_word) && $stable(prox_q))
    else $error("measurement moved while powered off");

  cov_als_done: cover property (als_done);
  cov_prox_done: cover property (prox_done ##[1:20] state_q == SEQ_ALS);
  cov_wait_run: cover property (state_q == SEQ_WAIT ##1 state_q == SEQ_IDLE);
  cov_gesture: cover property ($rose(gesture_active_out));
endmodule
`default_nettype wire

// ### hw/sensor_pkg.sv
// shared types of the sensor enable and timing block
`include "sensor_defs.svh"
package sensor_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_PROX = 4'b0010,
    SEQ_ALS  = 4'b0100,
    SEQ_WAIT = 4'b1000
  } seq_state_t;
  typedef enum logic [4:0] {
    BUS_IDLE  = 5'b00001,
    BUS_ADDR  = 5'b00010,
    BUS_PTR   = 5'b00100,
    BUS_WRITE = 5'b01000,
    BUS_READ  = 5'b10000
  } bus_state_t;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef logic [`COLOR_CHANNELS-1:0][`SAMPLE_W-1:0] color_sample_t;
  typedef struct packed {
    logic light;
    logic prox;
  } irq_req_t;
endpackage

// ### hw/step_timer.sv
// step pulse divider that runs only while the oscillator is on
`timescale 1ns/1ps
`default_nettype none
`include "sensor_defs.svh"
module step_timer #(
  parameter int STEP_CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic run_in,
  output logic      step_out
);
  localparam int W = $clog2(STEP_CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(STEP_CYCLES - 1);
  logic [W-1:0] cnt_q;
  logic         step_q;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
      step_q <= 1'b0;
    end else if (!run_in) begin
      // restart from zero so a new power-on gives a full first step
      cnt_q <= '0;
      step_q <= 1'b0;
    end else begin
      step_q <= (cnt_q == LAST);
      cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + W'(1);
    end
  end
  assign step_out = step_q;
endmodule
`default_nettype wire

// ### verif/i2c_host.sv
// host model: two-wire controller that writes and reads sensor registers
`timescale 1ns/1ps
`default_nettype none
module i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary value
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  localparam int HALF = 8;
  logic ack_ok;
  // clock and data stand high between frames, pulled up
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
    ack_ok = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // data moves two clocks after the fall so it never races the clock edge
  task automatic put_bit(input logic b);
    sda_oe_out = ~b;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(2);
  endtask
  task automatic get_bit(output logic b);
    sda_oe_out = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF / 2);
    b = sda_in;
    tick(HALF / 2);
    scl_out = 1'b0;
    tick(2);
  endtask
  task automatic start_cond();
    sda_oe_out = 1'b0;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_oe_out = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sda_oe_out = 1'b1;
    tick(HALF);
    scl_out = 1'b1;
    tick(HALF);
    sda_oe_out = 1'b0;
    tick(HALF);
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    get_bit(a);
    ack_ok = ack_ok & ~a;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    ack_ok = 1'b1;
    start_cond();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    send_byte(d);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    ack_ok = 1'b1;
    start_cond();
    send_byte({DEV_ADDR, 1'b0});
    send_byte(a);
    start_cond();
    send_byte({DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// testbench: enable and integration timing block driven by the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sensor_pkg::*;
  localparam int STEP = 8;
  localparam int LIMIT = 60000;
  logic          ref_clk, rst_b, scl, host_oe, dut_oe, osc, col, prx, wt;
  logic          lirq, pirq, gest, gesture_mode_field;
  color_sample_t color;
  irq_req_t      irq;
  logic [15:0]   prox_s, thr;
  int            fail_count, cmp_count, cyc, d;
  wire logic     sda;
  // open drain with pull-up: low whenever either side pulls
  assign sda = ~(host_oe | dut_oe);
  sensor_enable_and_als_timing #(.STEP_CYCLES(STEP)) u_sensor_enable_and_als_timing (
    .ref_clk_in(ref_clk), .rst_b_in(rst_b), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_out(dut_oe), .color_sample_in(color), .prox_sample_in(prox_s),
    .gesture_mode_in(gesture_mode_field), .gesture_entry_thr_in(thr), .irq_req_in(irq),
    .osc_run_out(osc), .color_active_out(col), .prox_active_out(prx),
    .wait_active_out(wt), .light_irq_out(lirq), .prox_irq_out(pirq),
    .gesture_active_out(gest));
  i2c_host u_i2c_host (.clk_in(ref_clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    u_i2c_host.write_reg(a, v);
    check(u_i2c_host.ack_ok, 1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    u_i2c_host.read_reg(a, v);
    check(u_i2c_host.ack_ok, 1);
    check(v, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? col : (k == 1 ? prx : wt);
  endfunction
  // second phase only: the first may start part way into a step
  task automatic span(input int k, output int dur);
    int n;
    for (int r = 0; r < 2; r++) begin
      n = 0;
      dur = 0;
      while (!pick(k) && n < 3000) begin idle(1); n++; end
      while (pick(k) && dur < 3000) begin idle(1); dur++; end
    end
  endtask
  task automatic t_reset();
    check({osc, col, prx, wt, lirq, pirq, gest}, 0);
    rd(8'h80, 8'h00);
    rd(8'h81, 8'hff);
    wr(8'h82, 8'h5a);
    rd(8'h82, 8'h00);
    wr(8'h80, 8'h80);
    rd(8'h80, 8'h00);
  endtask
  task automatic t_integration();
    color[0] = 11'h400;
    color[1] = 11'h1f4;
    wr(8'h81, 8'hc0);
    wr(8'h80, 8'h03);
    check(osc, 1);
    span(0, d);
    check((d + STEP / 2) / STEP, 64);
    rd(8'h94, 8'hff);
    rd(8'h95, 8'hff);
    rd(8'h96, 8'h00);
    rd(8'h97, 8'h7d);
  endtask
  task automatic t_power_off();
    wr(8'h80, 8'h0e);
    rd(8'h80, 8'h08);
    check({osc, col}, 0);
    color = '0;
    idle(20 * STEP);
    check(col, 0);
    rd(8'h95, 8'hff);
    wr(8'h80, 8'h00);
  endtask
  task automatic t_prox_wait();
    prox_s = 16'h1234;
    wr(8'h83, 8'hfe);
    wr(8'h80, 8'h0d);
    span(1, d);
    check((d + STEP / 2) / STEP, 1);
    span(2, d);
    check((d + STEP / 2) / STEP, 2);
    check(col, 0);
    rd(8'h93, 8'h02);
    rd(8'h9c, 8'h34);
    rd(8'h9d, 8'h12);
    wr(8'h80, 8'h00);
  endtask
  task automatic t_irq();
    logic [7:0] en;
    irq = '{light: 1'b1, prox: 1'b1};
    for (int i = 0; i < 4; i++) begin
      en = 8'(i << 4);
      wr(8'h80, en);
      idle(3);
      check(lirq, en[4]);
      check(pirq, en[5]);
    end
  endtask
  task automatic t_gesture();
    thr = 16'hffff;
    gesture_mode_field = 1'b1;
    wr(8'h80, 8'h41);
    idle(3);
    check(gest, 1);
    gesture_mode_field = 1'b0;
    idle(3);
    check(gest, 0);
    thr = 16'h1000;
    idle(3);
    check(gest, 1);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      $display("wrong value at %0t: run did not finish", $time);
      wrap_up();
    end
  end
  initial begin
    rst_b = 1'b0;
    color = '0;
    irq = '0;
    prox_s = 16'h0000;
    thr = 16'h0000;
    gesture_mode_field = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    idle(12);
    rst_b = 1'b1;
    idle(6);
    t_reset();
    t_integration();
    t_power_off();
    t_prox_wait();
    t_irq();
    t_gesture();
    wrap_up();
  end
endmodule
`default_nettype wire
